// ### core/ccg_cfg_bank.sv
// Functional notes
// - three pins form index, high pin MSB
// - byte zero bit7 is read-only variant flag
// - revision and vendor fields read-only
// - no writes accepted while save runs
// - stored lock refuses all further saves
// - locked: writes still apply, never saved
// - power down stops pll, tristates outputs
// - power down never stored as one
// - input clock select: crystal, vcxo, lvcmos
// - two low slave address bits programmable
// - first output source: input or pll
// - pin function effective only once stored
// - grounded supply: serial pins; address zero in control-pin mode
// - two state definitions decode four modes
// - ten-bit divider, zero holds reset
// - pick byte bit chooses state per index
// - load cap code, clamps at 20 pF
// - bytes move most significant bit first
// - each received byte applies immediately
// - save starts only on trigger rising edge
`timescale 1ns/10ps
`default_nettype none
`include "ccg_defines.svh"
module ccg_cfg_bank
  import ccg_pkg::*;
#(
  parameter logic P_VARIANT = `CCG_VARIANT,
  parameter logic [2:0] P_REVISION = `CCG_REVISION,
  parameter logic [3:0] P_VENDOR = `CCG_VENDOR
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // setting pins; mid and high double as serial data and clock
  input wire logic i_setting_pin_low,
  input wire logic i_setting_pin_mid,
  input wire logic i_setting_pin_high,
  // serial data open-drain drive
  output logic o_sda_out,
  output logic o_sda_oe_n,
  // output supply forced to ground
  input wire logic i_output_supply_grounded,
  // controls toward clock path and analog
  output logic o_serial_bus_active,
  output logic [2:0] o_setting_index,
  output logic [1:0] o_first_output_mode,
  output logic o_pll_power_down,
  output logic o_first_output_source,
  output logic [9:0] o_first_output_divider,
  output logic o_divider_in_reset,
  output logic [1:0] o_input_clock_select,
  output logic [4:0] o_load_cap_pf,
  output logic o_nvm_busy
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    logic scl_q;
    logic sda_q;
    ccg_phase_t phase;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic rnw;
    logic block;
    logic cmd_seen;
    logic ack_of_addr;
    logic ack_ok;
    logic [6:0] ptr;
    logic drive_low;
    logic [7:0] ctrl;
    logic [7:0] src;
    logic [7:0] divlo;
    logic [7:0] pick;
    logic [7:0] load;
    logic trig;
    logic [2:0] idx;
    ccg_out_mode_t mode;
    logic pll_pd;
    logic [9:0] div;
    logic [4:0] cap_pf;
    logic [1:0] input_clock_select;
    logic source;
  } ccg_bank_st_t;

  localparam ccg_bank_st_t RST_ST = '{
    scl_q: 1'b1,
    sda_q: 1'b1,
    phase: PH_IDLE,
    ctrl: `CCG_RST_CTRL,
    src: `CCG_RST_SRC,
    divlo: `CCG_RST_DIVLO,
    pick: `CCG_RST_PICK,
    load: `CCG_RST_LOAD,
    mode: OUT_TRI,
    div: 10'h001,
    cap_pf: 5'h0A,
    source: 1'b1,
    default: '0
  };

  ccg_bank_st_t st;
  ccg_bank_st_t next_st;
  ccg_cfg_if cfg();
  logic serial_active;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [7:0] rx;
  logic wr_fire;
  logic data_done;
  logic [7:0] rd_now;
  logic rd_msb;

  // ----------------------------------------
  // register read decode
  // ----------------------------------------
  // shared by first-byte load and block continuation
  function automatic logic [7:0] read_byte(input logic [6:0] ofs, input ccg_bank_st_t s, input logic busy);
    case (ofs)
      `CCG_OFS_IDENT: read_byte = {P_VARIANT, P_REVISION, P_VENDOR};
      `CCG_OFS_CTRL: read_byte = {1'b0, busy, s.ctrl[5:0]};
      `CCG_OFS_SRC: read_byte = s.src;
      `CCG_OFS_DIVLO: read_byte = s.divlo;
      `CCG_OFS_PICK: read_byte = s.pick;
      `CCG_OFS_LOAD: read_byte = s.load;
      `CCG_OFS_SAVE: read_byte = {7'h00, s.trig};
      default: read_byte = 8'h00;
    endcase
  endfunction

  // ----------------------------------------
  // submodules
  // ----------------------------------------
  ccg_setting_pick u_pick (
    .cfg(cfg)
  );

  ccg_nvm_engine u_nvm (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .cfg(cfg)
  );

  // working values toward pick and save engine
  assign cfg.setting_index = st.idx;
  assign cfg.state_pick_byte = st.pick;
  assign cfg.state_a = st.src[`CCG_FLD_STA];
  assign cfg.state_b = st.src[`CCG_FLD_STB];
  assign cfg.power_down = st.ctrl[`CCG_BIT_POWER_DOWN_BIT];
  assign cfg.save_trigger = st.trig;
  assign cfg.image_ctrl = st.ctrl;
  assign cfg.image_pinfn = st.src[`CCG_BIT_PINFN];

  // ----------------------------------------
  // bus pin view
  // ----------------------------------------
  // control-pin mode parks the bus idle so no start is seen
  assign serial_active = !cfg.stored_pinfn || i_output_supply_grounded;
  assign scl = serial_active ? i_setting_pin_high : 1'b1;
  assign sda = serial_active ? i_setting_pin_mid : 1'b1;
  assign scl_rise = scl && !st.scl_q;
  assign scl_fall = !scl && st.scl_q;
  assign start_c = scl && st.scl_q && st.sda_q && !sda;
  assign stop_c = scl && st.scl_q && !st.sda_q && sda;
  assign rx = {st.shreg[6:0], sda};
  assign data_done = scl_rise && (st.phase == PH_RECV) && (st.bitcnt == 4'h7) && st.cmd_seen;
  assign wr_fire = data_done && !cfg.busy && !start_c && !stop_c;
  assign rd_now = read_byte(st.ptr, st, cfg.busy);
  assign rd_msb = rd_now[7];

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    next_st.scl_q = scl;
    next_st.sda_q = sda;
    if (stop_c) begin
      next_st.phase = PH_IDLE;
      next_st.drive_low = 1'b0;
    end else if (start_c) begin
      next_st.phase = PH_ADDR;
      next_st.bitcnt = 4'h0;
      next_st.drive_low = 1'b0;
    end else begin
      case (st.phase)
        PH_ADDR, PH_RECV: begin
          if (scl_rise) begin
            next_st.shreg = rx;
            next_st.bitcnt = st.bitcnt + 4'h1;
            if (st.bitcnt == 4'h7) begin
              next_st.bitcnt = 4'h0;
              next_st.phase = PH_ACK;
              next_st.ack_of_addr = (st.phase == PH_ADDR);
              if (st.phase == PH_ADDR) begin
                next_st.rnw = rx[0];
                next_st.ack_ok = (rx[7:1] == {`CCG_ADDR_BASE, st.ctrl[`CCG_FLD_ADR]});
                if (!rx[0]) begin
                  next_st.cmd_seen = 1'b0;
                end
              end else if (!st.cmd_seen) begin
                // command: top bit picks single byte over block
                next_st.ack_ok = 1'b1;
                next_st.cmd_seen = 1'b1;
                next_st.ptr = rx[6:0];
                next_st.block = !rx[7];
              end else begin
                next_st.ack_ok = !cfg.busy;
                if (st.block && !cfg.busy) begin
                  next_st.ptr = st.ptr + 7'h01;
                end
              end
            end
          end
        end
        PH_ACK: begin
          if (scl_fall && (st.bitcnt == 4'h0)) begin
            next_st.drive_low = st.ack_ok;
            next_st.bitcnt = 4'h1;
          end else if (scl_fall) begin
            next_st.bitcnt = 4'h0;
            next_st.drive_low = 1'b0;
            if (!st.ack_ok) begin
              next_st.phase = PH_IDLE;
            end else if (st.ack_of_addr && st.rnw) begin
              next_st.phase = PH_RDATA;
              next_st.drive_low = !rd_now[7];
              next_st.shreg = {rd_now[6:0], 1'b0};
            end else begin
              next_st.phase = PH_RECV;
            end
          end
        end
        PH_RDATA: begin
          if (scl_rise) begin
            next_st.bitcnt = st.bitcnt + 4'h1;
            if (st.bitcnt == 4'h7) begin
              next_st.phase = PH_MACK;
              next_st.bitcnt = 4'h0;
            end
          end else if (scl_fall) begin
            next_st.drive_low = !st.shreg[7];
            next_st.shreg = {st.shreg[6:0], 1'b0};
          end
        end
        PH_MACK: begin
          // master ack continues the read, nack ends it
          if (scl_fall && (st.bitcnt == 4'h0)) begin
            next_st.drive_low = 1'b0;
            next_st.bitcnt = 4'h1;
          end else if (scl_rise && (st.bitcnt == 4'h1)) begin
            if (sda) begin
              next_st.phase = PH_IDLE;
            end else begin
              next_st.bitcnt = 4'h2;
              if (st.block) begin
                next_st.ptr = st.ptr + 7'h01;
              end
            end
          end else if (scl_fall && (st.bitcnt == 4'h2)) begin
            next_st.phase = PH_RDATA;
            next_st.bitcnt = 4'h0;
            next_st.drive_low = !rd_now[7];
            next_st.shreg = {rd_now[6:0], 1'b0};
          end
        end
        PH_IDLE: begin
          next_st.drive_low = 1'b0;
        end
        default: begin
          next_st.phase = PH_IDLE;
          next_st.drive_low = 1'b0;
        end
      endcase
    end

    // byte store; identity and unmapped offsets drop the data
    if (wr_fire) begin
      case (st.ptr)
        `CCG_OFS_CTRL: next_st.ctrl = {2'h0, rx[5:0]};
        `CCG_OFS_SRC: next_st.src = rx;
        `CCG_OFS_DIVLO: next_st.divlo = rx;
        `CCG_OFS_PICK: next_st.pick = rx;
        `CCG_OFS_LOAD: next_st.load = {rx[`CCG_FLD_CAP], 3'h0};
        `CCG_OFS_SAVE: next_st.trig = rx[`CCG_BIT_TRIG];
        default: begin
          next_st.trig = st.trig;
        end
      endcase
    end

    // grounded supply in control-pin mode clears the address bits
    if (cfg.stored_pinfn && i_output_supply_grounded) begin
      next_st.ctrl[`CCG_FLD_ADR] = 2'h0;
    end

    // pins read as zero while they serve the bus
    next_st.idx = {serial_active ? 1'b0 : i_setting_pin_high,
                   serial_active ? 1'b0 : i_setting_pin_mid,
                   i_setting_pin_low};
    next_st.mode = cfg.out_mode;
    next_st.pll_pd = cfg.pll_pd;
    next_st.div = {st.src[`CCG_FLD_DIVHI], st.divlo};
    next_st.cap_pf = (st.load[`CCG_FLD_CAP] > `CCG_CAP_MAX) ? `CCG_CAP_MAX : st.load[`CCG_FLD_CAP];
    next_st.input_clock_select = st.ctrl[`CCG_FLD_INPUT_CLOCK_SELECT];
    next_st.source = st.src[`CCG_BIT_SRC];
  end

  // state register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= RST_ST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_sda_out = 1'b0;
  assign o_sda_oe_n = !st.drive_low;
  assign o_serial_bus_active = serial_active;
  assign o_setting_index = st.idx;
  assign o_first_output_mode = st.mode;
  assign o_pll_power_down = st.pll_pd;
  assign o_first_output_source = st.source;
  assign o_first_output_divider = st.div;
  assign o_divider_in_reset = (st.div == 10'h000);
  assign o_input_clock_select = st.input_clock_select;
  assign o_load_cap_pf = st.cap_pf;
  assign o_nvm_busy = cfg.busy;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_trig_rise;
    !cfg.save_trigger ##1 cfg.save_trigger;
  endsequence

  sequence s_load_read;
    (st.phase == PH_ACK) && (st.bitcnt == 4'h1) && scl_fall && st.ack_ok && st.ack_of_addr && st.rnw;
  endsequence

  busy_write_block_a: assert property (
    data_done && cfg.busy |=> (st.src == $past(st.src)) && (st.divlo == $past(st.divlo))
      && (st.pick == $past(st.pick)) && (st.load == $past(st.load)) && !st.ack_ok)
    else $error("write taken during save cycle");

  write_lands_a: assert property (
    wr_fire && (st.ptr == `CCG_OFS_DIVLO) |=> st.divlo == $past(rx))
    else $error("received byte not stored");

  addr_force_a: assert property (
    cfg.stored_pinfn && i_output_supply_grounded |=> st.ctrl[`CCG_FLD_ADR] == 2'h0)
    else $error("address bits not cleared");

  index_pins_a: assert property (
    !serial_active |=> o_setting_index == $past({i_setting_pin_high, i_setting_pin_mid, i_setting_pin_low}))
    else $error("setting index mismatch");

  power_down_out_a: assert property (
    st.ctrl[`CCG_BIT_POWER_DOWN_BIT] |=> (o_first_output_mode == OUT_TRI) && o_pll_power_down)
    else $error("power down not applied");

  cap_clamp_a: assert property (
    (st.load[`CCG_FLD_CAP] >= `CCG_CAP_MAX) |=> o_load_cap_pf == `CCG_CAP_MAX)
    else $error("load cap not clamped");

  read_msb_a: assert property (
    s_load_read |=> st.drive_low == !$past(rd_msb))
    else $error("read byte not msb first");

  save_start_a: assert property (
    s_trig_rise ##0 (!cfg.busy && !cfg.stored_ctrl[`CCG_BIT_LOCK]) |=> cfg.busy)
    else $error("save not started on rising trigger");

  held_no_save_a: assert property (
    cfg.save_trigger && $past(cfg.save_trigger) && !cfg.busy |=> !cfg.busy)
    else $error("held trigger restarted save");

  lock_refuse_a: assert property (
    cfg.stored_ctrl[`CCG_BIT_LOCK] && !cfg.busy |=> !cfg.busy)
    else $error("save ran after lock stored");

  power_down_bit_unstored_a: assert property (
    !cfg.stored_ctrl[`CCG_BIT_POWER_DOWN_BIT])
    else $error("power down stored");

endmodule
`default_nettype wire

// ### core/ccg_defines.svh
`ifndef CCG_DEFINES_SVH
`define CCG_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCG_OFS_IDENT 7'h00
`define CCG_OFS_CTRL 7'h01
`define CCG_OFS_SRC 7'h02
`define CCG_OFS_DIVLO 7'h03
`define CCG_OFS_PICK 7'h04
`define CCG_OFS_LOAD 7'h05
`define CCG_OFS_SAVE 7'h06
// ----------------------------------------
// field positions
// ----------------------------------------
`define CCG_BIT_BUSY 6
`define CCG_BIT_LOCK 5
`define CCG_BIT_POWER_DOWN_BIT 4
`define CCG_FLD_INPUT_CLOCK_SELECT 3:2
`define CCG_FLD_ADR 1:0
`define CCG_BIT_SRC 7
`define CCG_BIT_PINFN 6
`define CCG_FLD_STB 5:4
`define CCG_FLD_STA 3:2
`define CCG_FLD_DIVHI 1:0
`define CCG_FLD_CAP 7:3
`define CCG_BIT_TRIG 0
// ----------------------------------------
// reset values; identity values arbitrary
// ----------------------------------------
`define CCG_RST_CTRL 8'h01
`define CCG_RST_SRC 8'hB4
`define CCG_RST_DIVLO 8'h01
`define CCG_RST_PICK 8'h02
`define CCG_RST_LOAD 8'h50
`define CCG_VARIANT 1'h1
`define CCG_REVISION 3'h2
`define CCG_VENDOR 4'h6
`define CCG_ADDR_BASE 5'h19
`define CCG_CAP_MAX 5'h14
// ----------------------------------------
// timing
// ----------------------------------------
`define CCG_CLK_PERIOD_NS 8
`define CCG_NVM_WRITE_NS 20000
`define CCG_NVM_WRITE_CYC ((`CCG_NVM_WRITE_NS + `CCG_CLK_PERIOD_NS - 1) / `CCG_CLK_PERIOD_NS)
`endif

// ### core/ccg_pkg.sv
package ccg_pkg;
  // serial engine phases, one-hot
  typedef enum logic [5:0] {
    PH_IDLE = 6'h01,
    PH_ADDR = 6'h02,
    PH_RECV = 6'h04,
    PH_ACK = 6'h08,
    PH_RDATA = 6'h10,
    PH_MACK = 6'h20
  } ccg_phase_t;
  // first output state codes
  typedef enum logic [1:0] {
    OUT_POWER_DOWN_BIT = 2'h0,
    OUT_TRI = 2'h1,
    OUT_LOW = 2'h2,
    OUT_ON = 2'h3
  } ccg_out_mode_t;
  // save engine state
  typedef struct packed {
    logic busy;
    logic trig_q;
    logic [15:0] count;
    logic [7:0] stored_ctrl;
    logic stored_pinfn;
  } ccg_nvm_st_t;
endpackage

// ### core/ccg_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ccg_cfg_if;
  import ccg_pkg::*;
  logic [2:0] setting_index;
  logic [7:0] state_pick_byte;
  logic [1:0] state_a;
  logic [1:0] state_b;
  logic power_down;
  logic save_trigger;
  logic [7:0] image_ctrl;
  logic image_pinfn;
  ccg_out_mode_t out_mode;
  logic pll_pd;
  logic busy;
  logic [7:0] stored_ctrl;
  logic stored_pinfn;
  modport bank(
    output setting_index, state_pick_byte, state_a, state_b, power_down,
    output save_trigger, image_ctrl, image_pinfn,
    input out_mode, pll_pd, busy, stored_ctrl, stored_pinfn
  );
  modport pick(input setting_index, state_pick_byte, state_a, state_b, power_down, output out_mode, pll_pd);
  modport nvm(input save_trigger, image_ctrl, image_pinfn, output busy, stored_ctrl, stored_pinfn);
endinterface
`default_nettype wire

// ### core/ccg_setting_pick.sv
`timescale 1ns/10ps
`default_nettype none
module ccg_setting_pick
  import ccg_pkg::*;
(
  // bank side
  ccg_cfg_if.pick cfg
);
  // chosen state definition; power down wins over any pin choice
  always_comb begin
    logic [1:0] chosen;
    chosen = cfg.state_pick_byte[cfg.setting_index] ? cfg.state_b : cfg.state_a;
    if (cfg.power_down) begin
      cfg.out_mode = OUT_TRI;
      cfg.pll_pd = 1'b1;
    end else begin
      cfg.out_mode = ccg_out_mode_t'(chosen);
      cfg.pll_pd = (chosen == OUT_POWER_DOWN_BIT);
    end
  end
endmodule
`default_nettype wire

// ### core/ccg_nvm_engine.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccg_defines.svh"
module ccg_nvm_engine
  import ccg_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // bank side
  ccg_cfg_if.nvm cfg
);
  localparam logic [15:0] WRITE_CYC = 16'(`CCG_NVM_WRITE_CYC);
  ccg_nvm_st_t st;
  ccg_nvm_st_t next_st;
  // save sequencer; a held trigger or a stored lock starts nothing
  always_comb begin
    next_st = st;
    next_st.trig_q = cfg.save_trigger;
    if (st.busy) begin
      next_st.count = st.count - 16'h0001;
      if (st.count == 16'h0001) begin
        next_st.busy = 1'b0;
        next_st.stored_ctrl = cfg.image_ctrl;
        next_st.stored_ctrl[`CCG_BIT_POWER_DOWN_BIT] = 1'b0;
        next_st.stored_pinfn = cfg.image_pinfn;
      end
    end else if (cfg.save_trigger && !st.trig_q && !st.stored_ctrl[`CCG_BIT_LOCK]) begin
      next_st.busy = 1'b1;
      next_st.count = WRITE_CYC;
    end
  end
  // state register
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st <= '{stored_ctrl: `CCG_RST_CTRL, default: '0};
    end else begin
      st <= next_st;
    end
  end
  assign cfg.busy = st.busy;
  assign cfg.stored_ctrl = st.stored_ctrl;
  assign cfg.stored_pinfn = st.stored_pinfn;
endmodule
`default_nettype wire

// ### dv/ccg_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// two-wire host controller model
// ----------------------------------------
module ccg_host_model (
  // clock
  input wire logic i_clk_sys,
  // device drive, low pulls the data wire
  input wire logic i_sda_oe_n,
  // bus wires
  output logic o_scl,
  output logic o_sda
);
  logic sda_drv = 1'b1;
  initial o_scl = 1'b1;
  // pull-up: wire low when either side pulls
  assign o_sda = sda_drv & i_sda_oe_n;
  // four clocks a phase, well above the device's one-clock sampling of each wire
  task automatic hold();
    repeat (4) @(posedge i_clk_sys);
    #1;
  endtask
  // data moves only while the clock is low, sampled before the fall
  task automatic bitx(input logic b, output logic r);
    sda_drv = b;
    hold();
    o_scl = 1'b1;
    hold();
    r = o_sda;
    o_scl = 1'b0;
    hold();
  endtask
  task automatic start();
    sda_drv = 1'b1;
    hold();
    o_scl = 1'b1;
    hold();
    sda_drv = 1'b0;
    hold();
    o_scl = 1'b0;
    hold();
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    hold();
    o_scl = 1'b1;
    hold();
    sda_drv = 1'b1;
    hold();
  endtask
  // byte out, ninth bit high means refused
  task automatic put(input logic [7:0] b, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(b[i], r);
    bitx(1'b1, nak);
  endtask
  task automatic get(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(1'b1, d[i]);
    bitx(last, r);
  endtask
  // offsets stay far below 20h
  task automatic wr(input logic [6:0] adr, input logic [6:0] ofs, input logic single, input logic [7:0] q[$],
                    output logic [7:0] naks);
    logic n;
    start();
    put({adr, 1'b0}, n);
    put({single, ofs}, n);
    foreach (q[k]) put(q[k], naks[k]);
    stop();
  endtask
  // two bytes with a master ack between; block mode steps the offset
  task automatic rd(input logic [6:0] adr, input logic [6:0] ofs, input logic single, output logic [15:0] d);
    logic n;
    start();
    put({adr, 1'b0}, n);
    put({single, ofs}, n);
    start();
    put({adr, 1'b1}, n);
    get(1'b0, d[15:8]);
    get(1'b1, d[7:0]);
    stop();
  endtask
endmodule
`default_nettype wire

// ### dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "ccg_defines.svh"
module testbench;
  import ccg_pkg::*;
  logic i_clk_sys, i_rst_n, i_setting_pin_low, i_output_supply_grounded, scl, sda, o_sda_out, o_sda_oe_n;
  logic o_serial_bus_active, o_pll_power_down, o_first_output_source, o_divider_in_reset, o_nvm_busy;
  logic [2:0] o_setting_index;
  logic [1:0] o_first_output_mode, o_input_clock_select;
  logic [9:0] o_first_output_divider;
  logic [4:0] o_load_cap_pf;
  logic [7:0] mdl [0:7];
  logic [7:0] lfsr = 8'h09;
  logic [7:0] naks;
  logic [15:0] d;
  logic [7:0] q[$];
  logic busy_exp = 1'b0;
  int num_errors = 0;
  int total_checks = 0;
  ccg_cfg_bank i_ccg_cfg_bank (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_setting_pin_low(i_setting_pin_low),
    .i_setting_pin_mid(sda), .i_setting_pin_high(scl), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .i_output_supply_grounded(i_output_supply_grounded), .o_serial_bus_active(o_serial_bus_active),
    .o_setting_index(o_setting_index), .o_first_output_mode(o_first_output_mode),
    .o_pll_power_down(o_pll_power_down), .o_first_output_source(o_first_output_source),
    .o_first_output_divider(o_first_output_divider), .o_divider_in_reset(o_divider_in_reset),
    .o_input_clock_select(o_input_clock_select), .o_load_cap_pf(o_load_cap_pf), .o_nvm_busy(o_nvm_busy));
  ccg_host_model i_ccg_host_model (.i_clk_sys(i_clk_sys), .i_sda_oe_n(o_sda_oe_n), .o_scl(scl), .o_sda(sda));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end
  task automatic check(input logic [9:0] seen, input logic [9:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // reference bank: reserved bits and the busy flag always land as zero
  function automatic void apply(input int o, input logic [7:0] v);
    if (o >= 1 && o <= 6) mdl[o] = v;
    mdl[1][7:6] = 2'b00;
    mdl[5][2:0] = 3'b000;
    mdl[6][7:1] = 7'h00;
  endfunction
  task automatic write(input int o, input logic single);
    i_ccg_host_model.wr({`CCG_ADDR_BASE, mdl[1][1:0]}, o[6:0], single, q, naks);
    foreach (q[k]) begin
      check(naks[k], busy_exp, "write ack");
      if (!busy_exp) apply(single ? o : o + k, q[k]);
    end
  endtask
  task automatic read(input int o, input logic [7:0] exp);
    i_ccg_host_model.rd({`CCG_ADDR_BASE, mdl[1][1:0]}, o[6:0], 1'b1, d);
    check(d[15:8], exp, "read byte");
    check(d[7:0], exp, "read again");
  endtask
  // derived controls, all settled after the stop phase
  task automatic expect_outputs();
    logic [1:0] st;
    st = mdl[4][i_setting_pin_low] ? mdl[2][5:4] : mdl[2][3:2];
    check(o_setting_index, {2'b00, i_setting_pin_low}, "index");
    check(o_first_output_mode, mdl[1][4] ? 2'd1 : st, "mode");
    check(o_pll_power_down, mdl[1][4] | (st == 2'd0), "pll down");
    check(o_first_output_source, mdl[2][7], "source");
    check(o_first_output_divider, {mdl[2][1:0], mdl[3]}, "divider");
    check(o_divider_in_reset, {mdl[2][1:0], mdl[3]} == 10'd0, "div reset");
    check(o_input_clock_select, mdl[1][3:2], "input_clock_select");
    check(o_load_cap_pf, mdl[5][7:3] > 5'd20 ? 5'd20 : mdl[5][7:3], "load cap");
    check(o_sda_out, 1'b0, "data level");
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_setting_pin_low = 1'b0;
    i_output_supply_grounded = 1'b0;
    mdl = '{{`CCG_VARIANT, `CCG_REVISION, `CCG_VENDOR}, 8'h01, 8'hb4, 8'h01, 8'h02, 8'h50, 8'h00, 8'h00};
    repeat (2) @(posedge i_clk_sys);
    #1;
    i_rst_n = 1'b1;
    repeat (2) @(posedge i_clk_sys);
    #1;
    expect_outputs();
    for (int o = 0; o < 8; o++) read(o, mdl[o]);
    $display("test reset values done");
    // random single writes over every offset, identity and unused ones too
    for (int k = 0; k < 24; k++) begin
      lfsr = lfsr_next(lfsr);
      i_setting_pin_low = lfsr[0];
      q = '{lfsr & (k % 8 == 1 ? 8'h7f : k % 8 == 5 ? 8'hf8 : k % 8 == 6 ? 8'h00 : 8'hff)};
      write(k % 8, 1'b1);
      expect_outputs();
      read(k % 8, mdl[k % 8]);
    end
    $display("test random writes done");
    // block writes: state code 00 then 10, divider held in reset after the second
    q = '{8'h83, 8'h00};
    write(2, 1'b0);
    expect_outputs();
    q = '{8'h28, 8'h00};
    write(2, 1'b0);
    expect_outputs();
    // block read walks the offset across the master ack
    i_ccg_host_model.rd({`CCG_ADDR_BASE, mdl[1][1:0]}, 7'h02, 1'b0, d);
    check(d[15:8], mdl[2], "block read first");
    check(d[7:0], mdl[3], "block read next");
    $display("test block writes done");
    // save with lock, power down and control-pin mode in the image
    q = '{8'h7c};
    write(2, 1'b1);
    q = '{8'h31};
    write(1, 1'b1);
    check(o_serial_bus_active, 1'b1, "pins before save");
    q = '{8'h01};
    write(6, 1'b1);
    busy_exp = 1'b1;
    check(o_nvm_busy, 1'b1, "save busy");
    q = '{8'h55};
    write(3, 1'b1);
    read(1, mdl[1] | 8'h40);
    for (int n = 0; n < 3000 && o_nvm_busy !== 1'b0; n++) @(posedge i_clk_sys);
    #1;
    busy_exp = 1'b0;
    check(o_nvm_busy, 1'b0, "save done");
    check(o_serial_bus_active, 1'b0, "pins after save");
    // idle bus wires now read as control pins, both high
    @(posedge i_clk_sys);
    #1;
    check(o_setting_index, {2'b11, i_setting_pin_low}, "pin index");
    $display("test save done");
    // grounded supply reopens the bus at address bits 00; lock refuses saves
    i_output_supply_grounded = 1'b1;
    mdl[1][1:0] = 2'b00;
    repeat (4) @(posedge i_clk_sys);
    #1;
    check(o_serial_bus_active, 1'b1, "grounded bus");
    q = '{8'h00};
    write(6, 1'b1);
    q = '{8'h01};
    write(6, 1'b1);
    repeat (2) @(posedge i_clk_sys);
    #1;
    check(o_nvm_busy, 1'b0, "locked save");
    q = '{8'h07};
    write(3, 1'b1);
    expect_outputs();
    read(1, mdl[1]);
    $display("test lock done");
    stop_test();
  end
  // watchdog: run takes about 35000 cycles
  initial begin
    repeat (60000) @(posedge i_clk_sys);
    num_errors++;
    $display("watchdog expired");
    stop_test();
  end
endmodule
`default_nettype wire
